// ### verilog/smm_pkg.sv
// constants shared by both ends of the management/suspend/float link
// assumes one 10 MHz double_clock, phases 1 and 2 on alternate edges
// How it works
// - system pulls management pin low to request
// - device samples management pin at phase 1
// - system holds request low four cycles minimum
// - device drives pin low four cycles later
// - after resume instruction, pin high two cycles
// - then device releases pin to input
// - system keeps released pin inactive high
// - trap request leads cycle-done by three edges
// - trapped I/O enters handler with nothing between
// - coprocessor cycles are never trapped
// - suspend waits for drain and busy negated
// - request suspend honoured only when enable bit set
// - suspend request sampled at phase 2
// - acknowledge no sooner than two cycles after
// - acknowledge drops four cycles after request inactive
// - request suspend: hold acknowledged, events recorded
// - halt suspend acknowledged within 17 cycles
// - halt suspend exits 12 cycles after interrupt
// - halt suspend: hold acknowledged, only flush recorded
// - system suspends before stopping the clock
// - stopped clock keeps state, inputs ignored
// - float request aborts cycle, floats all pins
// - float held 16 cycles, left through reset
package smm_pkg;

    localparam logic [4:0] SMI_DRIVE_DELAY = 5'h04; // sample to drive low
    localparam logic [4:0] END_HIGH_CYCLES = 5'h02; // closing high pulse
    localparam logic [4:0] SMI_MIN_LOW     = 5'h04; // request hold time
    localparam logic [4:0] IO_TRAP_LEAD    = 5'h03; // edges before ready
    localparam logic [4:0] ACK_LAT_MIN     = 5'h02; // least ack latency
    localparam logic [4:0] ACK_OFF_DELAY   = 5'h04; // ack release latency
    localparam logic [4:0] HALT_ACK_MAX    = 5'h11; // longest halt ack
    localparam logic [4:0] HALT_ACK_CYCLES = 5'h04; // halt ack latency used
    localparam logic [4:0] HALT_EXIT_DELAY = 5'h0c; // wake to ack release
    localparam logic [4:0] FLOAT_MIN       = 5'h10; // least float hold
    localparam logic [4:0] FLOAT_EXIT_RST  = 5'h02; // reset cycles on exit

    typedef enum logic [1:0] {
        SMI_IDLE = 2'b00,
        SMI_WAIT = 2'b01,
        SMI_LOW  = 2'b10,
        SMI_HIGH = 2'b11
    } smi_state_t;

    typedef enum logic [2:0] {
        SUS_RUN       = 3'b000,
        SUS_DRAIN     = 3'b001,
        SUS_ACTIVE    = 3'b010,
        SUS_LEAVE     = 3'b011,
        HALT_WAIT     = 3'b100,
        HALT_ACTIVE   = 3'b101,
        HALT_LEAVE    = 3'b110
    } sus_state_t;

endpackage

// ### verilog/smm_link_if.sv
// link between the processor control end and the system logic end
// assumes both ends on one clock; shared pins resolved here with pull-ups
interface smm_link_if;
    logic smi_dev_o;       // device drive level for management pin
    logic smi_dev_oe;      // device drives management pin
    logic smi_sys_o;       // system drive level for management pin
    logic smi_sys_oe;      // system drives management pin
    logic smi_n;           // resolved management pin
    logic suspend_req_n;   // suspend request from system
    logic suspend_ack_drv; // device drive level for acknowledge
    logic suspend_ack_oe;  // device drives acknowledge
    logic suspend_ack_n;   // resolved acknowledge
    logic float_req_n;     // float request from system
    logic cycle_done_n;    // bus cycle done from system
    logic io_cycle;        // current bus cycle is I/O
    logic copro_cycle;     // current bus cycle targets coprocessor
    logic dev_reset_n;     // reset request from system to device

    // wired level with internal pull-up
    assign smi_n = smi_dev_oe ? smi_dev_o :
                   (smi_sys_oe ? smi_sys_o : 1'b1);
    assign suspend_ack_n = suspend_ack_oe ? suspend_ack_drv : 1'b1;

    modport device (
        input  smi_n, suspend_req_n, float_req_n, cycle_done_n,
        output smi_dev_o, smi_dev_oe, suspend_ack_drv, suspend_ack_oe,
        output io_cycle, copro_cycle
    );
    modport system (
        input  smi_n, suspend_ack_n, io_cycle, copro_cycle,
        output smi_sys_o, smi_sys_oe, suspend_req_n, float_req_n,
        output cycle_done_n, dev_reset_n
    );
endinterface

// ### verilog/smm_device.sv
// processor end: management pin handshake, I/O trap, suspend, float
// assumes link inputs synchronous except float and suspend requests
module smm_device (
    input  wire logic     clk_i,
    input  wire logic     reset_n_i,
    smm_link_if.device    link,
    input  wire logic     resume_exec_i,        // resume instruction done
    input  wire logic     suspend_enable_bit_i, // config_control_zero bit
    input  wire logic     pipeline_drained_i,   // instr and cycles done
    input  wire logic     copro_busy_n_i,
    input  wire logic     halt_done_i,          // halt cycle done pulse
    input  wire logic     nmi_i,
    input  wire logic     maskable_irq_i,
    input  wire logic     irq_enable_i,
    input  wire logic     flush_req_n_i,
    input  wire logic     hold_req_i,
    input  wire logic     io_cycle_i,
    input  wire logic     copro_cycle_i,
    output logic          hold_ack_o,
    output logic          smm_active_o,
    output logic          io_trap_o,
    output logic          suspended_o,
    output logic          flush_replay_o,
    output logic          nmi_replay_o,
    output logic          irq_replay_o,
    output logic          bus_abort_o,
    output logic          float_o
);
    smm_pkg::smi_state_t smi_q;
    smm_pkg::sus_state_t sus_q;
    logic       phase_q;       // 0: next edge begins phase 1
    logic [4:0] smi_cnt_q;
    logic [4:0] sus_cnt_q;
    logic       frq_s1_q, frq_s2_q, sus_s1_q, sus_s2_q;
    logic       sus_smp_q;     // suspend request sampled active
    logic       float_q;
    logic       trap_arm_q;
    logic       smi_pend_q, flush_pend_q, nmi_pend_q, irq_pend_q;
    logic       flush_rp_q, nmi_rp_q, irq_rp_q, hold_ack_q;
    logic       phase1_edge, phase2_edge, smi_seen, smi_start;
    logic       req_suspend_req_n, halt_suspend_req_n, exit_now, irq_evt, arm_now;

    assign phase1_edge = ~phase_q;
    assign phase2_edge = phase_q;
    assign smi_seen    = phase1_edge && (smi_q == smm_pkg::SMI_IDLE)
                         && !link.smi_n;
    assign req_suspend_req_n    = (sus_q == smm_pkg::SUS_ACTIVE)
                         || (sus_q == smm_pkg::SUS_LEAVE);
    assign halt_suspend_req_n   = (sus_q == smm_pkg::HALT_ACTIVE)
                         || (sus_q == smm_pkg::HALT_LEAVE);
    assign smi_start   = (smi_seen || smi_pend_q)
                         && (sus_q == smm_pkg::SUS_RUN);
    assign exit_now    = (sus_cnt_q == 5'h00)
                         && ((sus_q == smm_pkg::SUS_LEAVE)
                             || (sus_q == smm_pkg::HALT_LEAVE));
    assign irq_evt     = maskable_irq_i && irq_enable_i;
    assign arm_now     = smi_start && io_cycle_i && !copro_cycle_i;

    // phase tracker: internal clock is half the double_clock
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    // two-stage synchronisers for the asynchronous requests
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frq_s1_q <= 1'b1;
            frq_s2_q <= 1'b1;
            sus_s1_q <= 1'b1;
            sus_s2_q <= 1'b1;
        end else begin
            frq_s1_q <= link.float_req_n;
            frq_s2_q <= frq_s1_q;
            sus_s1_q <= link.suspend_req_n;
            sus_s2_q <= sus_s1_q;
        end
    end

    // suspend request level taken only at phase 2 edges
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sus_smp_q <= 1'b0;
        end else if (phase2_edge) begin
            sus_smp_q <= !sus_s2_q;
        end
    end

    // float: held until reset, which is the only way out
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            float_q <= 1'b0;
        end else if (!frq_s2_q) begin
            float_q <= 1'b1;
        end
    end
    assign bus_abort_o = !frq_s2_q && !float_q;
    assign float_o     = float_q;

    // management pin sequencer
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            smi_q     <= smm_pkg::SMI_IDLE;
            smi_cnt_q <= 5'h00;
        end else begin
            unique case (smi_q)
                smm_pkg::SMI_IDLE: begin
                    if (smi_start) begin
                        smi_q     <= smm_pkg::SMI_WAIT;
                        smi_cnt_q <= smm_pkg::SMI_DRIVE_DELAY - 5'h01;
                    end
                end
                smm_pkg::SMI_WAIT: begin
                    if (smi_cnt_q == 5'h00) begin
                        smi_q <= smm_pkg::SMI_LOW;
                    end else begin
                        smi_cnt_q <= smi_cnt_q - 5'h01;
                    end
                end
                smm_pkg::SMI_LOW: begin
                    if (resume_exec_i) begin
                        smi_q     <= smm_pkg::SMI_HIGH;
                        smi_cnt_q <= smm_pkg::END_HIGH_CYCLES - 5'h01;
                    end
                end
                smm_pkg::SMI_HIGH: begin
                    if (smi_cnt_q == 5'h00) begin
                        smi_q <= smm_pkg::SMI_IDLE;
                    end else begin
                        smi_cnt_q <= smi_cnt_q - 5'h01;
                    end
                end
            endcase
        end
    end
    assign smm_active_o = (smi_q == smm_pkg::SMI_LOW);

    // pin drive; everything floats in float mode
    assign link.smi_dev_oe = !float_q && ((smi_q == smm_pkg::SMI_LOW)
                             || (smi_q == smm_pkg::SMI_HIGH));
    assign link.smi_dev_o  = (smi_q == smm_pkg::SMI_HIGH);
    assign link.suspend_ack_oe  = !float_q;
    assign link.suspend_ack_drv = !suspended_o;
    assign link.io_cycle    = io_cycle_i && !float_q;
    assign link.copro_cycle = copro_cycle_i && !float_q;

    // I/O trap: request during an I/O cycle enters the handler at its end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            trap_arm_q <= 1'b0;
        end else if (!link.cycle_done_n) begin
            trap_arm_q <= 1'b0;
        end else if (arm_now) begin
            trap_arm_q <= 1'b1;
        end
    end
    assign io_trap_o = !link.cycle_done_n
                       && (trap_arm_q || arm_now);

    // suspend sequencer, request and halt initiated
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sus_q     <= smm_pkg::SUS_RUN;
            sus_cnt_q <= 5'h00;
        end else begin
            unique case (sus_q)
                smm_pkg::SUS_RUN: begin
                    if (phase2_edge && !sus_s2_q
                        && suspend_enable_bit_i) begin
                        sus_q     <= smm_pkg::SUS_DRAIN;
                        sus_cnt_q <= smm_pkg::ACK_LAT_MIN - 5'h01;
                    end else if (halt_done_i) begin
                        sus_q     <= smm_pkg::HALT_WAIT;
                        sus_cnt_q <= smm_pkg::HALT_ACK_CYCLES - 5'h01;
                    end
                end
                smm_pkg::SUS_DRAIN: begin
                    if (!sus_smp_q) begin
                        sus_q <= smm_pkg::SUS_RUN;
                    end else if (sus_cnt_q != 5'h00) begin
                        sus_cnt_q <= sus_cnt_q - 5'h01;
                    end else if (pipeline_drained_i && copro_busy_n_i) begin
                        sus_q <= smm_pkg::SUS_ACTIVE;
                    end
                end
                smm_pkg::SUS_ACTIVE: begin
                    if (phase2_edge && sus_s2_q) begin
                        sus_q     <= smm_pkg::SUS_LEAVE;
                        sus_cnt_q <= smm_pkg::ACK_OFF_DELAY - 5'h01;
                    end
                end
                smm_pkg::HALT_WAIT: begin
                    if (sus_cnt_q == 5'h00) begin
                        sus_q <= smm_pkg::HALT_ACTIVE;
                    end else begin
                        sus_cnt_q <= sus_cnt_q - 5'h01;
                    end
                end
                smm_pkg::HALT_ACTIVE: begin
                    if (nmi_i || irq_evt) begin
                        sus_q     <= smm_pkg::HALT_LEAVE;
                        sus_cnt_q <= smm_pkg::HALT_EXIT_DELAY - 5'h01;
                    end
                end
                smm_pkg::SUS_LEAVE, smm_pkg::HALT_LEAVE: begin
                    if (sus_cnt_q == 5'h00) begin
                        sus_q <= smm_pkg::SUS_RUN;
                    end else begin
                        sus_cnt_q <= sus_cnt_q - 5'h01;
                    end
                end
                default: begin
                    sus_q <= smm_pkg::SUS_RUN;
                end
            endcase
        end
    end
    // state is static flops, so a stopped clock freezes it
    assign suspended_o = req_suspend_req_n || halt_suspend_req_n;

    // events recorded while suspended, replayed on exit; exit clear wins over set
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            smi_pend_q   <= 1'b0;
            flush_pend_q <= 1'b0;
            nmi_pend_q   <= 1'b0;
            irq_pend_q   <= 1'b0;
            flush_rp_q   <= 1'b0;
            nmi_rp_q     <= 1'b0;
            irq_rp_q     <= 1'b0;
        end else begin
            if (smi_seen && req_suspend_req_n) begin
                smi_pend_q <= 1'b1;
            end else if (smi_start) begin
                smi_pend_q <= 1'b0;
            end
            flush_pend_q <= !exit_now && (flush_pend_q
                            || (suspended_o && !flush_req_n_i));
            nmi_pend_q   <= !exit_now && (nmi_pend_q
                            || (req_suspend_req_n && nmi_i));
            irq_pend_q   <= !exit_now && (irq_pend_q
                            || (req_suspend_req_n && irq_evt));
            flush_rp_q   <= exit_now && (flush_pend_q || !flush_req_n_i);
            nmi_rp_q     <= exit_now && req_suspend_req_n && (nmi_pend_q || nmi_i);
            irq_rp_q     <= exit_now && req_suspend_req_n && (irq_pend_q || irq_evt);
        end
    end
    assign flush_replay_o = flush_rp_q;
    assign nmi_replay_o   = nmi_rp_q;
    assign irq_replay_o   = irq_rp_q;

    // hold stays acknowledged in every suspend flavour
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_ack_q <= 1'b0;
        end else begin
            hold_ack_q <= hold_req_i;
        end
    end
    assign hold_ack_o = hold_ack_q;

endmodule // smm_device

// ### verilog/smm_system.sv
// system logic end: requests management, traps I/O, suspends, floats
// assumes the bench joins dev_reset_n into the device reset
module smm_system (
    input  wire logic     clk_i,
    input  wire logic     reset_n_i,
    smm_link_if.system    link,
    input  wire logic     smi_req_i,     // pulse: request management
    input  wire logic     io_trap_i,     // level: trap current I/O
    input  wire logic     io_ready_i,    // pulse: end current bus cycle
    input  wire logic     suspend_i,     // level: want suspend
    input  wire logic     float_i,       // pulse: enter float
    input  wire logic     float_exit_i,  // pulse: leave float by reset
    output logic          smm_busy_o,
    output logic          suspended_o,
    output logic          clock_stop_ok_o,
    output logic          float_active_o
);
    logic [4:0] smi_cnt_q, trap_cnt_q, frq_cnt_q, exit_cnt_q;
    logic       done_q, sus_q, float_q, rst_q;
    logic       trap_go;

    assign trap_go = io_ready_i && io_trap_i && link.io_cycle
                     && !link.copro_cycle && (trap_cnt_q == 5'h00);

    // management pin pull, four cycles, only while the pin is idle high
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            smi_cnt_q <= 5'h00;
        end else if ((smi_req_i || trap_go) && smi_cnt_q == 5'h00
                     && link.smi_n) begin
            smi_cnt_q <= smm_pkg::SMI_MIN_LOW;
        end else if (smi_cnt_q != 5'h00) begin
            smi_cnt_q <= smi_cnt_q - 5'h01;
        end
    end
    assign link.smi_sys_oe = (smi_cnt_q != 5'h00);
    assign link.smi_sys_o  = 1'b0;

    // cycle done, delayed behind a trap request
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            trap_cnt_q <= 5'h00;
            done_q     <= 1'b0;
        end else begin
            done_q <= (io_ready_i && !trap_go && trap_cnt_q == 5'h00)
                      || (trap_cnt_q == 5'h01);
            if (trap_go) begin
                trap_cnt_q <= smm_pkg::IO_TRAP_LEAD;
            end else if (trap_cnt_q != 5'h00) begin
                trap_cnt_q <= trap_cnt_q - 5'h01;
            end
        end
    end
    assign link.cycle_done_n = !done_q;

    // suspend request level
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sus_q <= 1'b0;
        end else begin
            sus_q <= suspend_i;
        end
    end
    assign link.suspend_req_n = !sus_q;
    assign suspended_o     = !link.suspend_ack_n;
    assign clock_stop_ok_o = sus_q && !link.suspend_ack_n;
    assign smm_busy_o      = !link.smi_n && (smi_cnt_q == 5'h00);

    // float hold and reset-guarded exit
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            float_q    <= 1'b0;
            rst_q      <= 1'b0;
            frq_cnt_q  <= 5'h00;
            exit_cnt_q <= 5'h00;
        end else begin
            if (float_i && !float_q) begin
                float_q   <= 1'b1;
                frq_cnt_q <= smm_pkg::FLOAT_MIN - 5'h01;
            end else if (frq_cnt_q != 5'h00) begin
                frq_cnt_q <= frq_cnt_q - 5'h01;
            end
            if (float_exit_i && float_q && frq_cnt_q == 5'h00
                && !rst_q) begin
                rst_q      <= 1'b1;
                exit_cnt_q <= smm_pkg::FLOAT_EXIT_RST;
            end else if (rst_q) begin
                exit_cnt_q <= exit_cnt_q - 5'h01;
                if (exit_cnt_q == smm_pkg::FLOAT_EXIT_RST) begin
                    float_q <= 1'b0;
                end
                if (exit_cnt_q == 5'h01) begin
                    rst_q <= 1'b0;
                end
            end
        end
    end
    assign link.float_req_n = !float_q;
    assign link.dev_reset_n = !rst_q;
    assign float_active_o   = float_q;

endmodule // smm_system

// ### verif/smm_link_checker.sv
// checker: timing relations on the management/suspend/float link
// assumes one clock; reset_n_i is the bench reset of both ends
module smm_link_checker (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic smi_dev_o,
    input wire logic smi_dev_oe,
    input wire logic smi_sys_o,
    input wire logic smi_sys_oe,
    input wire logic smi_n,
    input wire logic suspend_req_n,
    input wire logic suspend_ack_n,
    input wire logic suspend_ack_oe,
    input wire logic float_req_n,
    input wire logic cycle_done_n,
    input wire logic io_cycle,
    input wire logic dev_reset_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // management pin, device side
    a_smi_drive_late:
        assert property ($rose(smi_dev_oe) |-> !smi_dev_o && !$past(smi_n, 4)
            && !$past(smi_n, 5)) else $error("pin driven before request");
    a_end_high_two:
        assert property ($rose(smi_dev_o) && smi_dev_oe |-> smi_dev_oe [*2]
            ##1 !smi_dev_oe) else $error("closing pulse not two cycles");
    a_release_after_high:
        assert property ($fell(smi_dev_oe) |-> $past(smi_dev_o, 1)
            && $past(smi_dev_o, 2)) else $error("pin released wrongly");
    // management pin, system side
    a_pull_when_idle:
        assert property ($rose(smi_sys_oe) |-> $past(smi_n))
        else $error("system pulled a busy pin");
    a_smi_hold_four:
        assert property ($rose(smi_sys_oe) |-> (smi_sys_oe && !smi_sys_o) [*4]
            ##1 !smi_sys_oe) else $error("request not held four cycles");
    a_trap_done_lead:
        assert property ($fell(cycle_done_n) && smi_sys_oe |->
            $past(smi_sys_oe, 3)) else $error("trap lead too short");
    // suspend handshake
    a_ack_min_latency:
        assert property ($fell(suspend_ack_n) && !suspend_req_n |->
            !$past(suspend_req_n, 2) && !$past(suspend_req_n, 3))
        else $error("acknowledge too early");
    a_ack_release_four:
        assert property ($rose(suspend_req_n) && !suspend_ack_n |->
            !suspend_ack_n [*4] ##[1:6] suspend_ack_n)
        else $error("acknowledge release out of window");
    // float mode
    a_float_releases:
        assert property ((!float_req_n && dev_reset_n) [*5] |-> !smi_dev_oe
            && !suspend_ack_oe && !io_cycle) else $error("pins not floated");
    a_float_exit_reset:
        assert property ($rose(float_req_n) |-> !dev_reset_n)
        else $error("float left without reset");
    c_service: cover property ($fell(smi_dev_oe));
    c_suspend: cover property ($rose(suspend_ack_n) && suspend_req_n);
    c_float: cover property ($rose(float_req_n));
endmodule // smm_link_checker

// ### verif/tb_top.sv
// bench: both ends joined by the link, scenarios through user ports
// assumes design files and link checker are compiled before this
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'h0, reset_n_i = 1'h0, dev_rst_n;
    logic resume = 1'h0, sus_en = 1'h0, drained = 1'h1, busy_n = 1'h1;
    logic halt = 1'h0, nmi = 1'h0, irq = 1'h0, irq_en = 1'h0, hold = 1'h0;
    logic flush_n = 1'h1, io_c = 1'h0, cp_c = 1'h0, smi_req = 1'h0;
    logic trap = 1'h0, ready = 1'h0, sus = 1'h0, frq = 1'h0, frq_x = 1'h0;
    logic hold_ack, smm_act, io_trap, d_suspend_req_n, fl_rep, nmi_rep, irq_rep;
    logic abort, float_o, busy, s_suspend_req_n, stop_ok, f_act, seen;
    int bad_count = 0, samples_checked = 0, n;
    smm_link_if link();
    // device reset also taken from the link for float exit
    assign dev_rst_n = reset_n_i & link.dev_reset_n;
    always #50 clk_i = ~clk_i;
    smm_device i_smm_device (.clk_i(clk_i), .reset_n_i(dev_rst_n),
        .link(link), .resume_exec_i(resume), .suspend_enable_bit_i(sus_en),
        .pipeline_drained_i(drained), .copro_busy_n_i(busy_n),
        .halt_done_i(halt), .nmi_i(nmi), .maskable_irq_i(irq),
        .irq_enable_i(irq_en), .flush_req_n_i(flush_n), .hold_req_i(hold),
        .io_cycle_i(io_c), .copro_cycle_i(cp_c), .hold_ack_o(hold_ack),
        .smm_active_o(smm_act), .io_trap_o(io_trap), .suspended_o(d_suspend_req_n),
        .flush_replay_o(fl_rep), .nmi_replay_o(nmi_rep),
        .irq_replay_o(irq_rep), .bus_abort_o(abort), .float_o(float_o));
    smm_system i_smm_system (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .link(link), .smi_req_i(smi_req), .io_trap_i(trap),
        .io_ready_i(ready), .suspend_i(sus), .float_i(frq),
        .float_exit_i(frq_x), .smm_busy_o(busy), .suspended_o(s_suspend_req_n),
        .clock_stop_ok_o(stop_ok), .float_active_o(f_act));
    smm_link_checker i_smm_link_checker (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .smi_dev_o(link.smi_dev_o),
        .smi_dev_oe(link.smi_dev_oe), .smi_sys_o(link.smi_sys_o),
        .smi_sys_oe(link.smi_sys_oe), .smi_n(link.smi_n),
        .suspend_req_n(link.suspend_req_n),
        .suspend_ack_n(link.suspend_ack_n),
        .suspend_ack_oe(link.suspend_ack_oe),
        .float_req_n(link.float_req_n), .cycle_done_n(link.cycle_done_n),
        .io_cycle(link.io_cycle), .dev_reset_n(link.dev_reset_n));
    // compare and count
    task automatic chk(input logic seen_v, input logic exp_v);
        samples_checked++;
        if (seen_v !== exp_v) begin
            bad_count++;
            $display("Error at %0t: saw %b expected %b", $time, seen_v, exp_v);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // resume instruction, then closing pulse and release
    task automatic end_smi;
        @(posedge clk_i) resume <= 1'h1;
        @(posedge clk_i) resume <= 1'h0;
        n = 0;
        repeat (6) begin
            @(negedge clk_i);
            if ((link.smi_dev_oe & link.smi_dev_o) === 1'h1) n++;
        end
        chk(n == 2, 1'h1);
        chk(link.smi_dev_oe, 1'h0);
        chk(link.smi_n, 1'h1);
    endtask
    task automatic t_smi;
        @(posedge clk_i) smi_req <= 1'h1;
        @(posedge clk_i) smi_req <= 1'h0;
        n = 0;
        do begin @(negedge clk_i); n++; end while (smm_act !== 1'h1 && n<20);
        chk(link.smi_n, 1'h0);
        chk(busy, 1'h1);
        end_smi();
    endtask
    // one I/O cycle with trap asked; coprocessor cycles never trap
    task automatic t_io(input logic cp, input logic exp_t);
        @(posedge clk_i) begin
            io_c <= 1'h1; cp_c <= cp; trap <= 1'h1; ready <= 1'h1;
        end
        @(posedge clk_i) ready <= 1'h0;
        seen = 1'h0;
        n = 0;
        repeat (12) begin
            @(negedge clk_i);
            if (link.cycle_done_n === 1'h0) begin n++; seen = io_trap; end
        end
        chk(n == 1, 1'h1);
        chk(seen, exp_t);
        chk(smm_act, exp_t);
        @(posedge clk_i) begin io_c <= 1'h0; cp_c <= 1'h0; trap <= 1'h0; end
        if (exp_t) end_smi();
    endtask
    task automatic t_sus;
        @(posedge clk_i) begin sus <= 1'h1; irq_en <= 1'h1; end
        repeat (20) @(negedge clk_i);
        chk(d_suspend_req_n, 1'h0);
        @(posedge clk_i) begin sus_en <= 1'h1; busy_n <= 1'h0; end
        repeat (20) @(negedge clk_i);
        chk(d_suspend_req_n, 1'h0);
        @(posedge clk_i) busy_n <= 1'h1;
        n = 0;
        do begin @(negedge clk_i); n++; end while (d_suspend_req_n !== 1'h1 && n < 20);
        chk(n >= 2 && n < 20, 1'h1);
        chk(s_suspend_req_n & stop_ok, 1'h1);
        @(posedge clk_i) begin hold <= 1'h1; nmi <= 1'h1; irq <= 1'h1; end
        @(posedge clk_i) nmi <= 1'h0;
        repeat (2) @(negedge clk_i);
        chk(hold_ack, 1'h1);
        @(posedge clk_i) begin hold <= 1'h0; sus <= 1'h0; end
        seen = 1'h0;
        n = 0;
        do begin
            @(negedge clk_i); n++; seen = seen | (nmi_rep & irq_rep);
        end while (d_suspend_req_n !== 1'h0 && n < 20);
        repeat (2) begin @(negedge clk_i); seen = seen | nmi_rep; end
        chk(n < 20, 1'h1);
        chk(seen, 1'h1);
    endtask
    task automatic t_halt;
        @(posedge clk_i) begin halt <= 1'h1; irq <= 1'h0; irq_en <= 1'h0; end
        @(posedge clk_i) halt <= 1'h0;
        n = 0;
        do begin @(negedge clk_i); n++; end while (d_suspend_req_n !== 1'h1 && n < 30);
        chk(n <= 17, 1'h1);
        @(posedge clk_i) begin irq <= 1'h1; flush_n <= 1'h0; end
        @(posedge clk_i) flush_n <= 1'h1;
        repeat (20) @(negedge clk_i);
        chk(d_suspend_req_n, 1'h1);
        @(posedge clk_i) irq_en <= 1'h1;
        seen = 1'h0;
        n = 0;
        do begin
            @(negedge clk_i); n++; seen = seen | fl_rep;
        end while (d_suspend_req_n !== 1'h0 && n < 30);
        repeat (2) begin @(negedge clk_i); seen = seen | fl_rep; end
        chk(n >= 12 && n <= 15, 1'h1);
        chk(seen, 1'h1);
        @(posedge clk_i) begin irq <= 1'h0; irq_en <= 1'h0; end
    endtask
    task automatic t_float;
        @(posedge clk_i) begin frq <= 1'h1; io_c <= 1'h1; end
        @(posedge clk_i) frq <= 1'h0;
        seen = 1'h0;
        n = 0;
        do begin
            @(negedge clk_i); n++; seen = seen | abort;
        end while (float_o !== 1'h1 && n < 10);
        chk(seen, 1'h1);
        chk(link.smi_dev_oe|link.suspend_ack_oe|link.io_cycle, 1'h0);
        repeat (20) @(negedge clk_i);
        chk(float_o & f_act, 1'h1);
        @(posedge clk_i) frq_x <= 1'h1;
        @(posedge clk_i) frq_x <= 1'h0;
        repeat (10) @(negedge clk_i);
        chk(float_o | f_act, 1'h0);
    endtask
    // reset, scenarios, verdict
    initial begin
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'h1;
        t_smi();
        t_io(1'h0, 1'h1);
        t_io(1'h1, 1'h0);
        t_sus();
        t_halt();
        t_float();
        conclude();
    end
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #2000000;
        bad_count++;
        $display("Error at %0t: run did not finish", $time);
        conclude();
    end
endmodule // tb_top
